// >>> common/bst_pkg.sv
`default_nettype none
package bst_pkg;
   // register widths
   localparam int IR_W  = 10;
   localparam int DR_W  = 32;
   // boundary chain: three cells per pin (input, output, enable); variants hold 240/480/636/816
   localparam int NPINS   = 80;
   localparam int BSR_LEN = 240;
   localparam int CELL_IN = 0;
   localparam int CELL_OUT = 1;
   localparam int CELL_OE = 2;
   // instruction codes
   localparam logic [IR_W-1:0] OP_SAMPLE = 10'h005;
   localparam logic [IR_W-1:0] OP_EXTEST = 10'h00f;
   localparam logic [IR_W-1:0] OP_BYPASS = 10'h3ff;
   localparam logic [IR_W-1:0] OP_UCODE  = 10'h007;
   localparam logic [IR_W-1:0] OP_IDENTIFICATION_REGISTER = 10'h006;
   localparam logic [IR_W-1:0] OP_HIGHZ  = 10'h00b;
   localparam logic [IR_W-1:0] OP_CLAMP  = 10'h00a;
   localparam logic [IR_W-1:0] OP_USERA  = 10'h00c;
   localparam logic [IR_W-1:0] OP_USERB  = 10'h00e;
   localparam logic [IR_W-1:0] IR_CAPT   = 10'h001;
   // identification fields (values arbitrary)
   localparam logic [3:0]  ID_VER  = 4'h1;
   localparam logic [15:0] ID_PART = 16'h5a3c;
   localparam logic [10:0] ID_MFR  = 11'h2a5;
   localparam logic [DR_W-1:0] UCODE_BLANK = 32'hffff_ffff;
   // tap states
   typedef enum logic [3:0] {
      TS_RESET, TS_IDLE, TS_SELDR, TS_CAPDR, TS_SHDR, TS_EX1DR, TS_PAUDR, TS_EX2DR, TS_UPDR,
      TS_SELIR, TS_CAPIR, TS_SHIR, TS_EX1IR, TS_PAUIR, TS_EX2IR, TS_UPIR
   } bst_tap_t;
   typedef enum logic [2:0] {DS_BYP, DS_ID, DS_UC, DS_BSR, DS_UA, DS_UB} bst_dsel_t;
   // host register map
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_TX     = 8'h04;
   localparam logic [7:0] REG_RX     = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0c;
   localparam int CTRL_GO    = 0;
   localparam int CTRL_IR    = 1;
   localparam int CTRL_RST   = 2;
   localparam int CTRL_KEEP  = 3;
   localparam int CTRL_LEN_L = 8;
   localparam int CTRL_LEN_H = 12;
   // link timing: half a test clock in system clocks
   localparam int HALF = 4;
   localparam logic [4:0] RESET_TMS = 5'd4;
   localparam logic [3:0] NAV_DR = 4'b0001;
   localparam logic [3:0] NAV_IR = 4'b0011;
   localparam logic [4:0] NAV_DR_N = 5'd2;
   localparam logic [4:0] NAV_IR_N = 5'd3;
endpackage
`default_nettype wire

// >>> common/bst_if.sv
`default_nettype none
interface bst_if;
   logic tck;
   logic tms;
   logic tdi;
   logic tdo;
   logic tdo_en;
   logic tdo_line;
   // weak pull-up on the serial output when the device does not drive it
   assign tdo_line = tdo_en ? tdo : 1'b1;
   modport dev (input tck, input tms, input tdi, output tdo, output tdo_en);
   modport host (output tck, output tms, output tdi, input tdo_line);
endinterface
`default_nettype wire

// >>> design/bst_tap_dev.sv
`default_nettype none
module bst_tap_dev (
   // link
   bst_if.dev                          lnk,
   // system reset, crossed into the test clock
   input  wire logic                   sys_rst,
   // pins and core side
   input  wire logic [bst_pkg::NPINS-1:0] pin_in,
   input  wire logic [bst_pkg::NPINS-1:0] core_out,
   input  wire logic [bst_pkg::NPINS-1:0] core_oe,
   output logic      [bst_pkg::NPINS-1:0] pin_out,
   output logic      [bst_pkg::NPINS-1:0] pin_oe,
   input  wire logic                   keeper_en,
   output logic                        keeper_act,
   // configuration
   input  wire logic                   ucode_valid,
   input  wire logic [31:0]            ucode_cfg,
   // user chains
   output logic                        user_sel_a,
   output logic                        user_sel_b,
   output logic                        user_tdi,
   output logic                        user_capture,
   output logic                        user_shift,
   output logic                        user_update,
   output bst_pkg::bst_tap_t           user_state,
   input  wire logic                   user_a_tdo,
   input  wire logic                   user_b_tdo
);
   logic                         rst_m;
   logic                         rst_t;
   logic [bst_pkg::NPINS-1:0]    pin_m;
   logic [bst_pkg::NPINS-1:0]    pin_s;
   bst_pkg::bst_tap_t            st;
   bst_pkg::bst_tap_t            next_st;
   logic [bst_pkg::IR_W-1:0]     ir_sh;
   logic [bst_pkg::IR_W-1:0]     ir;
   bst_pkg::bst_dsel_t           dsel;
   logic                         byp;
   logic [bst_pkg::DR_W-1:0]     dsh;
   logic [bst_pkg::BSR_LEN-1:0]  bsr_sh;
   logic [bst_pkg::BSR_LEN-1:0]  bsr_up;
   logic [bst_pkg::BSR_LEN-1:0]  bsr_cap;
   logic [bst_pkg::NPINS-1:0]    up_out;
   logic [bst_pkg::NPINS-1:0]    up_oe;
   logic                         user_on;

   // standard tap transition table
   function automatic bst_pkg::bst_tap_t tap_next(input bst_pkg::bst_tap_t s, input logic m);
      case (s)
         bst_pkg::TS_RESET: tap_next = m ? bst_pkg::TS_RESET : bst_pkg::TS_IDLE;
         bst_pkg::TS_IDLE:  tap_next = m ? bst_pkg::TS_SELDR : bst_pkg::TS_IDLE;
         bst_pkg::TS_SELDR: tap_next = m ? bst_pkg::TS_SELIR : bst_pkg::TS_CAPDR;
         bst_pkg::TS_CAPDR: tap_next = m ? bst_pkg::TS_EX1DR : bst_pkg::TS_SHDR;
         bst_pkg::TS_SHDR:  tap_next = m ? bst_pkg::TS_EX1DR : bst_pkg::TS_SHDR;
         bst_pkg::TS_EX1DR: tap_next = m ? bst_pkg::TS_UPDR : bst_pkg::TS_PAUDR;
         bst_pkg::TS_PAUDR: tap_next = m ? bst_pkg::TS_EX2DR : bst_pkg::TS_PAUDR;
         bst_pkg::TS_EX2DR: tap_next = m ? bst_pkg::TS_UPDR : bst_pkg::TS_SHDR;
         bst_pkg::TS_UPDR:  tap_next = m ? bst_pkg::TS_SELDR : bst_pkg::TS_IDLE;
         bst_pkg::TS_SELIR: tap_next = m ? bst_pkg::TS_RESET : bst_pkg::TS_CAPIR;
         bst_pkg::TS_CAPIR: tap_next = m ? bst_pkg::TS_EX1IR : bst_pkg::TS_SHIR;
         bst_pkg::TS_SHIR:  tap_next = m ? bst_pkg::TS_EX1IR : bst_pkg::TS_SHIR;
         bst_pkg::TS_EX1IR: tap_next = m ? bst_pkg::TS_UPIR : bst_pkg::TS_PAUIR;
         bst_pkg::TS_PAUIR: tap_next = m ? bst_pkg::TS_EX2IR : bst_pkg::TS_PAUIR;
         bst_pkg::TS_EX2IR: tap_next = m ? bst_pkg::TS_UPIR : bst_pkg::TS_SHIR;
         bst_pkg::TS_UPIR:  tap_next = m ? bst_pkg::TS_SELDR : bst_pkg::TS_IDLE;
         default:           tap_next = bst_pkg::TS_RESET;
      endcase
   endfunction

   // instruction decode; unknown codes fall back to bypass as the standard asks
   function automatic bst_pkg::bst_dsel_t ir_dec(input logic [bst_pkg::IR_W-1:0] c);
      case (c)
         bst_pkg::OP_SAMPLE, bst_pkg::OP_EXTEST: ir_dec = bst_pkg::DS_BSR;
         bst_pkg::OP_UCODE:  ir_dec = bst_pkg::DS_UC;
         bst_pkg::OP_IDENTIFICATION_REGISTER: ir_dec = bst_pkg::DS_ID;
         bst_pkg::OP_USERA:  ir_dec = bst_pkg::DS_UA;
         bst_pkg::OP_USERB:  ir_dec = bst_pkg::DS_UB;
         default:            ir_dec = bst_pkg::DS_BYP;
      endcase
   endfunction

   // reset and pin inputs cross into the test clock through two flops
   always_ff @(posedge lnk.tck) begin
      rst_m <= sys_rst;
      rst_t <= rst_m;
      pin_m <= pin_in;
      pin_s <= pin_m;
   end

   assign next_st = tap_next(st, lnk.tms);
   assign dsel = ir_dec(ir);
   assign user_on = (dsel == bst_pkg::DS_UA) || (dsel == bst_pkg::DS_UB);

   // tap controller
   always_ff @(posedge lnk.tck) begin
      if (rst_t) begin
         st <= bst_pkg::TS_RESET;
      end else begin
         st <= next_st;
      end
   end
   assign user_state = st;

   // boundary capture: input cell sees the pin, output cells see what is driven
   for (genvar i = 0; i < bst_pkg::NPINS; i++) begin : g_cell
      assign bsr_cap[3*i+bst_pkg::CELL_IN]  = pin_s[i];
      assign bsr_cap[3*i+bst_pkg::CELL_OUT] = pin_out[i];
      assign bsr_cap[3*i+bst_pkg::CELL_OE]  = pin_oe[i];
      assign up_out[i] = bsr_up[3*i+bst_pkg::CELL_OUT];
      assign up_oe[i]  = bsr_up[3*i+bst_pkg::CELL_OE];
   end

   // instruction shift stage
   always_ff @(posedge lnk.tck) begin
      if (st == bst_pkg::TS_CAPIR) begin
         ir_sh <= bst_pkg::IR_CAPT;
      end else if (st == bst_pkg::TS_SHIR) begin
         ir_sh <= {lnk.tdi, ir_sh[bst_pkg::IR_W-1:1]};
      end
   end

   // instruction and boundary update on the falling edge inside the update states
   always_ff @(negedge lnk.tck) begin
      if (rst_t || st == bst_pkg::TS_RESET) begin
         ir <= bst_pkg::OP_IDENTIFICATION_REGISTER;
      end else if (st == bst_pkg::TS_UPIR) begin
         ir <= ir_sh;
      end
   end

   always_ff @(negedge lnk.tck) begin
      if (rst_t) begin
         bsr_up <= '0;
      end else if (st == bst_pkg::TS_UPDR && dsel == bst_pkg::DS_BSR) begin
         bsr_up <= bsr_sh;
      end
   end

   // data registers: bypass, id/user_code_register word, boundary chain
   always_ff @(posedge lnk.tck) begin
      if (st == bst_pkg::TS_CAPDR) begin
         byp <= 1'b0;
         if (dsel == bst_pkg::DS_UC) begin
            dsh <= ucode_valid ? ucode_cfg : bst_pkg::UCODE_BLANK;
         end else begin
            dsh <= {bst_pkg::ID_VER, bst_pkg::ID_PART, bst_pkg::ID_MFR, 1'b1};
         end
         if (dsel == bst_pkg::DS_BSR) begin
            bsr_sh <= bsr_cap;
         end
      end else if (st == bst_pkg::TS_SHDR) begin
         byp <= lnk.tdi;
         dsh <= {lnk.tdi, dsh[bst_pkg::DR_W-1:1]};
         if (dsel == bst_pkg::DS_BSR) begin
            bsr_sh <= {lnk.tdi, bsr_sh[bst_pkg::BSR_LEN-1:1]};
         end
      end
   end

   // serial output changes on the falling edge, driven only while shifting
   always_ff @(negedge lnk.tck) begin
      if (rst_t) begin
         lnk.tdo    <= 1'b1;
         lnk.tdo_en <= 1'b0;
      end else begin
         lnk.tdo_en <= (st == bst_pkg::TS_SHIR) || (st == bst_pkg::TS_SHDR);
         if (st == bst_pkg::TS_SHIR) begin
            lnk.tdo <= ir_sh[0];
         end else begin
            case (dsel)
               bst_pkg::DS_ID, bst_pkg::DS_UC: lnk.tdo <= dsh[0];
               bst_pkg::DS_BSR: lnk.tdo <= bsr_sh[0];
               bst_pkg::DS_UA:  lnk.tdo <= user_a_tdo;
               bst_pkg::DS_UB:  lnk.tdo <= user_b_tdo;
               default:         lnk.tdo <= byp;
            endcase
         end
      end
   end

   // pin drivers; core values are expected to be launched on the test clock
   always_ff @(posedge lnk.tck) begin
      if (rst_t) begin
         pin_out <= '0;
         pin_oe  <= '0;
      end else if (ir == bst_pkg::OP_EXTEST || ir == bst_pkg::OP_CLAMP) begin
         pin_out <= up_out;
         pin_oe  <= up_oe;
      end else if (ir == bst_pkg::OP_HIGHZ) begin
         pin_out <= core_out;
         pin_oe  <= '0;
      end else begin
         pin_out <= core_out;
         pin_oe  <= core_oe;
      end
   end

   // weak pull / hold never follows the test instruction
   always_ff @(posedge lnk.tck) begin
      if (rst_t) begin
         keeper_act <= 1'b0;
      end else begin
         keeper_act <= keeper_en;
      end
   end

   // user chain hooks, in step with the state register
   always_ff @(posedge lnk.tck) begin
      if (rst_t) begin
         user_sel_a   <= 1'b0;
         user_sel_b   <= 1'b0;
         user_tdi     <= 1'b0;
         user_capture <= 1'b0;
         user_shift   <= 1'b0;
         user_update  <= 1'b0;
      end else begin
         user_sel_a   <= dsel == bst_pkg::DS_UA;
         user_sel_b   <= dsel == bst_pkg::DS_UB;
         user_tdi     <= lnk.tdi;
         user_capture <= user_on && next_st == bst_pkg::TS_CAPDR;
         user_shift   <= user_on && next_st == bst_pkg::TS_SHDR;
         user_update  <= user_on && next_st == bst_pkg::TS_UPDR;
      end
   end
endmodule
`default_nettype wire

// >>> design/bst_scan_host.sv
`default_nettype none
module bst_scan_host (
   // system
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // link
   bst_if.host              lnk
);
   typedef enum logic [2:0] {HS_IDLE, HS_RESET, HS_NAV, HS_SHIFT, HS_UPD, HS_RTI} bst_hst_t;

   bst_hst_t    hs;
   bst_hst_t    tgt;
   logic        wr_pend;
   logic [7:0]  wr_addr;
   logic [31:0] ctrl;
   logic [31:0] tx;
   logic [31:0] rx;
   logic        pend;
   logic        in_shift;
   logic [4:0]  cnt;
   logic [3:0]  nav;
   logic [1:0]  ph;
   logic        tdo_m;
   logic        tdo_s;
   logic        rise;
   logic        fall;
   logic        busy;
   logic        next_tms;

   assign busy = pend || hs != HS_IDLE;
   assign rise = ph == 2'(bst_pkg::HALF - 1) && !lnk.tck;
   assign fall = ph == 2'(bst_pkg::HALF - 1) && lnk.tck && busy;

   // sequence chosen by the pending command
   always_comb begin
      if (ctrl[bst_pkg::CTRL_RST]) begin
         tgt = HS_RESET;
      end else if (in_shift) begin
         tgt = HS_SHIFT;
      end else begin
         tgt = HS_NAV;
      end
   end

   // mode-select level for the step about to be clocked
   always_comb begin
      case ((hs == HS_IDLE && pend) ? tgt : hs)
         HS_RESET: next_tms = 1'b1;
         HS_NAV:   next_tms = (hs == HS_IDLE) ? bst_pkg::NAV_DR[0] : nav[0];
         HS_SHIFT: next_tms = cnt == 5'd0 && !ctrl[bst_pkg::CTRL_KEEP];
         HS_UPD:   next_tms = 1'b1;
         default:  next_tms = 1'b0;
      endcase
   end

   // test clock divider; parks high while idle, so no stray shift clocks
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ph      <= '0;
         lnk.tck <= 1'b0;
      end else if (ph == 2'(bst_pkg::HALF - 1)) begin
         ph      <= '0;
         if (busy || !lnk.tck) lnk.tck <= !lnk.tck;
      end else begin
         ph <= ph + 2'd1;
      end
   end

   // returning serial data is a foreign input
   always_ff @(posedge clk) begin
      tdo_m <= lnk.tdo_line;
      tdo_s <= tdo_m;
   end

   // bus slave: zero wait states, registered read data
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wr_pend   <= 1'b0;
         wr_addr   <= '0;
         hrdata    <= '0;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         wr_pend <= hsel && htrans[1] && hready && hwrite;
         wr_addr <= haddr[7:0];
         if (hsel && htrans[1] && hready && !hwrite) begin
            case (haddr[7:0])
               bst_pkg::REG_CTRL:   hrdata <= ctrl;
               bst_pkg::REG_TX:     hrdata <= tx;
               bst_pkg::REG_RX:     hrdata <= rx;
               bst_pkg::REG_STATUS: hrdata <= {30'h0, in_shift, busy};
               default:             hrdata <= '0;
            endcase
         end
      end
   end

   // command and transmit word; writes while busy are dropped
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrl <= '0;
         tx   <= '0;
         pend <= 1'b0;
      end else begin
         if (wr_pend && !busy && wr_addr == bst_pkg::REG_CTRL) begin
            ctrl <= hwdata;
            pend <= hwdata[bst_pkg::CTRL_GO];
         end else if (hs == HS_IDLE && pend && fall) begin
            pend <= 1'b0;
         end
         if (wr_pend && !busy && wr_addr == bst_pkg::REG_TX) begin
            tx <= hwdata;
         end else if (hs == HS_SHIFT && rise) begin
            tx <= {1'b0, tx[31:1]};
         end
      end
   end

   // link driver: levels change on falling edges, steps advance on rising edges
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         hs       <= HS_IDLE;
         lnk.tms  <= 1'b1;
         lnk.tdi  <= 1'b0;
         cnt      <= '0;
         nav      <= '0;
         rx       <= '0;
         in_shift <= 1'b0;
      end else if (fall) begin
         lnk.tms <= next_tms;
         lnk.tdi <= tx[0];
         if (hs == HS_IDLE && pend) begin
            hs <= tgt;
            if (tgt == HS_RESET) begin
               cnt      <= bst_pkg::RESET_TMS;
               in_shift <= 1'b0;
            end else if (tgt == HS_NAV) begin
               nav <= ctrl[bst_pkg::CTRL_IR] ? bst_pkg::NAV_IR : bst_pkg::NAV_DR;
               cnt <= ctrl[bst_pkg::CTRL_IR] ? bst_pkg::NAV_IR_N : bst_pkg::NAV_DR_N;
            end else begin
               cnt <= ctrl[bst_pkg::CTRL_LEN_H:bst_pkg::CTRL_LEN_L];
            end
         end
      end else if (rise) begin
         case (hs)
            HS_RESET: begin
               cnt <= cnt - 5'd1;
               if (cnt == 5'd0) begin
                  hs <= HS_RTI;
               end
            end
            HS_NAV: begin
               nav <= {1'b0, nav[3:1]};
               cnt <= cnt - 5'd1;
               if (cnt == 5'd0) begin
                  hs  <= HS_SHIFT;
                  cnt <= ctrl[bst_pkg::CTRL_LEN_H:bst_pkg::CTRL_LEN_L];
               end
            end
            HS_SHIFT: begin
               rx  <= {tdo_s, rx[31:1]};
               cnt <= cnt - 5'd1;
               if (cnt == 5'd0) begin
                  in_shift <= ctrl[bst_pkg::CTRL_KEEP];
                  hs       <= ctrl[bst_pkg::CTRL_KEEP] ? HS_IDLE : HS_UPD;
               end
            end
            HS_UPD:  hs <= HS_RTI;
            HS_RTI:  hs <= HS_IDLE;
            default: hs <= HS_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

// >>> test/bst_link_chk.sv
`default_nettype none
module bst_link_chk (
   // clocks and reset
   input  wire logic clk,
   input  wire logic sys_rst,
   input  wire logic tck,
   // link lines
   input  wire logic tms,
   input  wire logic tdi,
   input  wire logic tdo,
   input  wire logic tdo_en,
   input  wire logic tdo_line
);
   // next tap state, one nibble per state, lowest state first
   localparam logic [63:0] NXT0 = 64'h1bdd_bba1_4664_4311;
   localparam logic [63:0] NXT1 = 64'h2fef_cc02_8785_5920;
   logic [3:0] st;
   logic [2:0] ones;
   logic       known;
   logic [9:0] ir_sh;
   logic [9:0] ir;
   logic       byp;
   // the shadow tap is trusted only once five tms-high clocks have forced both taps to reset
   always_ff @(posedge tck or posedge sys_rst) begin
      if (sys_rst) begin
         ones  <= 3'h0;
         known <= 1'b0;
      end else begin
         ones  <= tms ? ((ones == 3'h5) ? ones : ones + 3'h1) : 3'h0;
         known <= known | (tms & (ones >= 3'h4));
      end
   end
   // shadow state register
   always_ff @(posedge tck) begin
      st <= (tms && ones >= 3'h4) ? 4'h0 : (tms ? NXT1[4*st +: 4] : NXT0[4*st +: 4]);
   end
   // shadow instruction: shifted lsb first, taken in update, id after reset
   always_ff @(posedge tck) begin
      if (st == bst_pkg::TS_SHIR) ir_sh <= {tdi, ir_sh[9:1]};
   end
   always_ff @(posedge tck) begin
      if (st == bst_pkg::TS_RESET) ir <= bst_pkg::OP_IDENTIFICATION_REGISTER;
      else if (st == bst_pkg::TS_UPIR) ir <= ir_sh;
   end
   // codes without a register of their own fall back to bypass
   assign byp = !(ir inside {bst_pkg::OP_SAMPLE, bst_pkg::OP_EXTEST, bst_pkg::OP_UCODE,
                             bst_pkg::OP_IDENTIFICATION_REGISTER, bst_pkg::OP_USERA, bst_pkg::OP_USERB});
   sequence s_ir_enter;
      st == bst_pkg::TS_CAPIR ##1 st == bst_pkg::TS_SHIR;
   endsequence
   sequence s_dr_enter;
      st == bst_pkg::TS_CAPDR ##1 st == bst_pkg::TS_SHDR;
   endsequence
   a_tdo_on_fall: assert property (@(posedge clk) disable iff (sys_rst) $changed(tdo) |-> !tck)
      else $error("serial output moved while test clock high");
   a_lines_settle: assert property (@(posedge clk) disable iff (sys_rst)
      ($changed(tms) || $changed(tdi)) |-> !tck) else $error("mode or data moved while test clock high");
   a_tck_high: assert property (@(posedge clk) disable iff (sys_rst) $rose(tck) |-> tck[*4])
      else $error("test clock high phase wrong");
   a_tck_low: assert property (@(posedge clk) disable iff (sys_rst) $fell(tck) |-> !tck[*4])
      else $error("test clock low phase too short");
   a_reset_idle: assert property (@(posedge clk) sys_rst |=> (!tck && tms && !tdi))
      else $error("link not parked during reset");
   a_drive_shift: assert property (@(posedge tck) disable iff (!known)
      tdo_en == (st == bst_pkg::TS_SHDR || st == bst_pkg::TS_SHIR)) else $error("output enable outside shift");
   a_ir_capture: assert property (@(posedge tck) disable iff (!known)
      s_ir_enter |-> tdo ##1 (st != bst_pkg::TS_SHIR || !tdo)) else $error("instruction capture bits wrong");
   a_bypass_zero: assert property (@(posedge tck) disable iff (!known)
      (s_dr_enter ##0 byp) |-> !tdo) else $error("bypass capture not zero");
   a_bypass_one: assert property (@(posedge tck) disable iff (!known)
      (st == bst_pkg::TS_SHDR && $past(st) == bst_pkg::TS_SHDR && byp) |-> tdo == $past(tdi))
      else $error("bypass path not one bit");
   a_id_lsb: assert property (@(posedge tck) disable iff (!known)
      (s_dr_enter ##0 ir == bst_pkg::OP_IDENTIFICATION_REGISTER) |-> tdo) else $error("id word lsb not one");
endmodule
`default_nettype wire

// >>> test/boundary_scan_tap_tb.sv
`default_nettype none
module boundary_scan_tap_tb;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {
      logic [9:0]  op;
      int          n;
      logic [31:0] tx;
      logic [31:0] exp;
      logic [31:0] msk;
   } bst_row_t;
   localparam logic [31:0] ID_WORD = {bst_pkg::ID_VER, bst_pkg::ID_PART, bst_pkg::ID_MFR, 1'b1};
   localparam logic [bst_pkg::NPINS-1:0] ONES = '1;
   // system and bus
   logic                      clk, sys_rst, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0]               haddr, hwdata, hrdata, ucode_cfg, rx;
   logic [1:0]                htrans;
   logic [2:0]                hsize;
   // pins, configuration and user chains
   logic [bst_pkg::NPINS-1:0] pin_in, core_out, core_oe, pin_out, pin_oe;
   logic                      keeper_en, keeper_act, ucode_valid, user_sel_a, user_sel_b, user_tdi, user_shift;
   wire logic                 user_a_tdo, user_b_tdo;
   int                        fails, num_checks, sh_cnt;
   bst_row_t                  rows [10];
   logic [9:0]                pops [4];
   bst_if lnk ();
   assign hready = hreadyout;
   // chain a hands the registered serial input back, chain b inverts it
   assign user_a_tdo = user_tdi;
   assign user_b_tdo = ~user_tdi;
   bst_scan_host i_bst_scan_host (.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .lnk(lnk.host));
   bst_tap_dev i_bst_tap_dev (.lnk(lnk.dev), .sys_rst(sys_rst), .pin_in(pin_in), .core_out(core_out),
      .core_oe(core_oe), .pin_out(pin_out), .pin_oe(pin_oe), .keeper_en(keeper_en), .keeper_act(keeper_act),
      .ucode_valid(ucode_valid), .ucode_cfg(ucode_cfg), .user_sel_a(user_sel_a), .user_sel_b(user_sel_b),
      .user_tdi(user_tdi), .user_capture(), .user_shift(user_shift), .user_update(), .user_state(),
      .user_a_tdo(user_a_tdo), .user_b_tdo(user_b_tdo));
   bst_link_chk i_bst_link_chk (.clk(clk), .sys_rst(sys_rst), .tck(lnk.tck), .tms(lnk.tms), .tdi(lnk.tdi),
      .tdo(lnk.tdo), .tdo_en(lnk.tdo_en), .tdo_line(lnk.tdo_line));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // shift clocks flagged to user logic
   always @(posedge lnk.tck) begin
      if (user_shift === 1'b1) sh_cnt <= sh_cnt + 1;
   end
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, got);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk_pins(input string what, input logic [bst_pkg::NPINS-1:0] exp, got);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   // single word transfer, address phase held until hready, then data phase
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= {24'h0, a};
      hwrite <= w;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   // one scan of n bits; the captured bits come back right aligned
   task automatic scan(input logic ir, input int n, input logic [31:0] tx, input logic keep, output logic [31:0] r);
      logic [31:0] s;
      bus(1'b1, bst_pkg::REG_TX, tx, s);
      bus(1'b1, bst_pkg::REG_CTRL, {19'h0, 5'(n - 1), 4'h0, keep, 1'b0, ir, 1'b1}, s);
      do bus(1'b0, bst_pkg::REG_STATUS, 32'h0, s); while (s[0] !== 1'b0);
      bus(1'b0, bst_pkg::REG_RX, 32'h0, r);
      r = r >> (32 - n);
   endtask
   task automatic load_ir(input logic [9:0] op);
      logic [31:0] r;
      scan(1'b1, bst_pkg::IR_W, {22'h0, op}, 1'b0, r);
      chk("instruction capture", {22'h0, bst_pkg::IR_CAPT}, r);
   endtask
   task automatic tap_reset();
      logic [31:0] s;
      bus(1'b1, bst_pkg::REG_CTRL, 32'h5, s);
      do bus(1'b0, bst_pkg::REG_STATUS, 32'h0, s); while (s[0] !== 1'b0);
   endtask
   // whole run needs some 7k system clocks, so 2 ms only trips on a hang
   initial begin
      #2_000_000;
      fails++;
      end_of_test();
   end
   initial begin
      sys_rst = 1'b1;
      {hsel, haddr, htrans, hwrite, hwdata} = '0;
      hsize = 3'b010;
      pin_in = {5{16'h96c3}};
      core_out = {5{16'h5a0f}};
      core_oe = {5{16'h33cc}};
      keeper_en = 1'b1;
      ucode_valid = 1'b0;
      ucode_cfg = 32'h3c5a_9617;
      {fails, num_checks, sh_cnt} = '0;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      bus(1'b0, bst_pkg::REG_STATUS, 32'h0, rx);
      chk("status idle", 32'h0, rx);
      bus(1'b1, 8'h10, 32'hdead_beef, rx);
      bus(1'b0, 8'h10, 32'h0, rx);
      chk("unmapped read", 32'h0, rx);
      $display("registers done");
      tap_reset();
      // sample capture order: per pin input, output, enable; cell 0 leaves first
      for (int j = 0; j < 32; j++)
         rows[0].exp[j] = (j % 3 == 0) ? pin_in[j/3] : (j % 3 == 1) ? core_out[j/3] : core_oe[j/3];
      rows = '{'{bst_pkg::OP_SAMPLE, 32, '1, rows[0].exp, '1}, '{bst_pkg::OP_EXTEST, 32, '1, rows[0].exp, 32'h4924_9249},
               '{bst_pkg::OP_IDENTIFICATION_REGISTER, 32, 0, ID_WORD, '1}, '{bst_pkg::OP_UCODE, 32, 0, bst_pkg::UCODE_BLANK, '1},
               '{bst_pkg::OP_BYPASS, 8, 32'ha5, 32'h4a, '1}, '{bst_pkg::OP_HIGHZ, 8, 32'ha5, 32'h4a, '1},
               '{bst_pkg::OP_CLAMP, 8, 32'ha5, 32'h4a, '1}, '{bst_pkg::OP_USERA, 8, 32'ha5, 32'h4a, 32'hfe},
               '{bst_pkg::OP_USERB, 8, 32'ha5, 32'hb4, 32'hfe}, '{10'h155, 8, 32'ha5, 32'h4a, '1}};
      foreach (rows[i]) begin
         load_ir(rows[i].op);
         sh_cnt = 0;
         scan(1'b0, rows[i].n, rows[i].tx, 1'b0, rx);
         chk("data scan", rows[i].exp & rows[i].msk, rx & rows[i].msk);
         chk("user select", {30'h0, rows[i].op == bst_pkg::OP_USERA, rows[i].op == bst_pkg::OP_USERB},
             {30'h0, user_sel_a, user_sel_b});
         if (rows[i].op inside {bst_pkg::OP_USERA, bst_pkg::OP_USERB})
            chk("user shift", 32'(rows[i].n), 32'(sh_cnt));
         $display("row %0d done", i);
      end
      // preload the whole boundary chain with ones, then walk the pin-holding codes and the id code that releases the pins
      load_ir(bst_pkg::OP_SAMPLE);
      for (int k = 0; k < bst_pkg::BSR_LEN / 32; k++) scan(1'b0, 32, '1, 1'b1, rx);
      scan(1'b0, bst_pkg::BSR_LEN % 32, '1, 1'b0, rx);
      pops = '{bst_pkg::OP_EXTEST, bst_pkg::OP_CLAMP, bst_pkg::OP_HIGHZ, bst_pkg::OP_IDENTIFICATION_REGISTER};
      foreach (pops[i]) begin
         load_ir(pops[i]);
         repeat (16) @(posedge clk);
         chk_pins("pin enable", (i == 3) ? core_oe : (i == 2) ? '0 : ONES, pin_oe);
         chk_pins("pin level", (i < 2) ? ONES : core_out, pin_out);
         chk("keeper", {31'h0, keeper_en}, {31'h0, keeper_act});
      end
      $display("pins done");
      ucode_valid <= 1'b1;
      load_ir(bst_pkg::OP_UCODE);
      scan(1'b0, 32, 32'h0, 1'b0, rx);
      chk("configured user code", ucode_cfg, rx);
      tap_reset();
      scan(1'b0, 32, 32'h0, 1'b0, rx);
      chk("id after tap reset", ID_WORD, rx);
      $display("tap reset done");
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk("reset levels", 32'h6, {28'h0, lnk.tck, lnk.tms, hreadyout, hresp});
      @(posedge clk) sys_rst <= 1'b0;
      $display("second reset done");
      end_of_test();
   end
endmodule
`default_nettype wire
